// file: rtl/dbt_pkg.sv
// Constants shared by the descriptor block transfer engine and its FIFO.
// Assumes a 16-bit on-chip RAM port and a 20 MHz ref_clk.
//
// Function
// - Both standby bits at one enter standby; both at zero leave it.
// - Source mode 10 increments the source address after each transfer.
// - Destination mode 10 increments the destination address per transfer.
// - Transfer mode field value 10 selects block transfer.
// - Size field value 01 selects two-byte word transfers.
// - Block side select one makes the source area restored per block.
// - Chain enable zero ends processing after the current descriptor.
// - Interrupt select zero raises the CPU interrupt only at count end.
// - NMI mode zero suspends an ongoing transfer while NMI is active.
// - Count A sets how many transfers the descriptor performs.
// - Count B gives data units moved per block per activation.
// - Source address is a full 32-bit read address.
// - Destination address is a full 32-bit write address.
// - Conversion end activates a transfer; CPU interrupt follows count end.
// - Descriptor start is vector entry low half plus base upper half.
// - Descriptor read as mode 0, count A 2, count B 6, src 8, dst 12.
// - Updated working registers are written back to RAM after transfer.
// - In block mode count A is a 16-bit count of blocks remaining.

package dbt_pkg;

    localparam int MW_SM_MSB = 15;
    localparam int MW_SM_LSB = 14;
    localparam int MW_DM_MSB = 13;
    localparam int MW_DM_LSB = 12;
    localparam int MW_MD_MSB = 11;
    localparam int MW_MD_LSB = 10;
    localparam int MW_SZ_MSB = 9;
    localparam int MW_SZ_LSB = 8;
    localparam int MW_BLOCK_SIDE = 7;
    localparam int MW_CHAIN = 6;
    localparam int MW_IRQ_SEL = 5;
    localparam int MW_NMI_MODE = 4;

    localparam logic [1:0] ADDR_INC = 2'h2;
    localparam logic [1:0] ADDR_DEC = 2'h3;
    localparam logic [1:0] XFER_BLOCK = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;

    // Descriptor word offsets from its start address
    localparam logic [31:0] DOFS_MODE = 32'h0000_0000;
    localparam logic [31:0] DOFS_CNT_A = 32'h0000_0002;
    localparam logic [31:0] DOFS_CNT_B = 32'h0000_0006;
    localparam logic [31:0] DOFS_SRC_HI = 32'h0000_0008;
    localparam logic [31:0] DOFS_SRC_LO = 32'h0000_000A;
    localparam logic [31:0] DOFS_DST_HI = 32'h0000_000C;
    localparam logic [31:0] DOFS_DST_LO = 32'h0000_000E;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
    localparam logic [2:0] DESC_LAST_IDX = 3'h6;

    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VEC,
        ST_FETCH,
        ST_READ,
        ST_WRITE,
        ST_WBACK
    } dbt_state_type;

endpackage : dbt_pkg

// file: rtl/dbt_stream_if.sv
// Valid/ready word stream between the engine and its data FIFO.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
`default_nettype none

interface dbt_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dbt_stream_if

`default_nettype wire

// file: rtl/dbt_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, synchronous reset and a freezing clock enable.
`timescale 1ns/10ps
`default_nettype none

module dbt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    dbt_stream_if.snk in_s,
    dbt_stream_if.src out_s
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;

    wire push = in_s.valid & in_s.ready;
    wire pop = out_s.valid & out_s.ready;

    assign in_s.ready = (count_q != FULL_CNT);
    assign out_s.valid = (count_q != '0);
    assign out_s.data = mem_q[rd_ptr_q];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge ref_clk) begin
                if (clk_en && push && wr_ptr_q == AW'(g)) begin
                    mem_q[g] <= in_s.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : dbt_fifo

`default_nettype wire

// file: rtl/dbt_block_transfer.sv
// Descriptor-driven block transfer engine with a RAM master port.
// Assumes a 16-bit RAM port that answers each request with one ack cycle
// and a conversion-end event pulse from the converter.
`timescale 1ns/10ps
`default_nettype none

module dbt_block_transfer
    import dbt_pkg::*;
#(
    parameter logic [31:0] VECTOR_ADDR = 32'h0000_0000
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic xfer_standby_hi,
    input wire logic xfer_standby_lo,
    input wire logic conversion_end_irq,
    input wire logic nmi_req,
    input wire logic [15:0] descriptor_base_upper,
    input wire logic act_enable_set,
    output logic act_enable,
    output logic in_standby,
    output logic busy,
    output logic cpu_irq,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // State

    dbt_state_type state_q;
    dbt_state_type state_d;
    logic [2:0] idx_q;
    logic [31:0] rf_q;
    logic [15:0] mode_q;
    logic [15:0] cnt_a_q;
    logic [15:0] blen_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [31:0] blk_src_q;
    logic [31:0] blk_dst_q;
    logic [15:0] rd_left_q;
    logic [15:0] wr_left_q;
    logic rd_fin_q;
    logic pend_q;
    logic act_en_q;
    logic stby_q;
    logic irq_due_q;
    logic irq_q;
    wire run = clk_en & ~stby_q;

    dbt_stream_if #(.WIDTH(FIFO_WIDTH)) push_s ();
    dbt_stream_if #(.WIDTH(FIFO_WIDTH)) pop_s ();

    dbt_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(run),
        .in_s(push_s),
        .out_s(pop_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] desc_ofs(input logic [2:0] i);
        logic [31:0] r;
        r = DOFS_MODE;
        case (i)
            3'h0: r = DOFS_MODE;
            3'h1: r = DOFS_CNT_A;
            3'h2: r = DOFS_CNT_B;
            3'h3: r = DOFS_SRC_HI;
            3'h4: r = DOFS_SRC_LO;
            3'h5: r = DOFS_DST_HI;
            3'h6: r = DOFS_DST_LO;
            default: r = DOFS_MODE;
        endcase
        return r;
    endfunction : desc_ofs

    // Unit size sets the address step
    function automatic logic [31:0] unit_step(input logic [1:0] sz);
        logic [31:0] r;
        r = STEP_WORD;
        case (sz)
            SIZE_BYTE: r = STEP_BYTE;
            SIZE_WORD: r = STEP_WORD;
            SIZE_LONG: r = STEP_LONG;
            default: r = STEP_WORD;
        endcase
        return r;
    endfunction : unit_step

    function automatic logic [31:0] next_addr(input logic [31:0] a,
                                              input logic [1:0] am,
                                              input logic [31:0] st);
        logic [31:0] r;
        r = a;
        case (am)
            ADDR_INC: r = a + st;
            ADDR_DEC: r = a - st;
            default: r = a;
        endcase
        return r;
    endfunction : next_addr

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire [1:0] src_mode = mode_q[MW_SM_MSB:MW_SM_LSB];
    wire [1:0] dst_mode = mode_q[MW_DM_MSB:MW_DM_LSB];
    wire [1:0] xfer_mode = mode_q[MW_MD_MSB:MW_MD_LSB];
    wire [1:0] unit_size = mode_q[MW_SZ_MSB:MW_SZ_LSB];
    wire block_side = mode_q[MW_BLOCK_SIDE];
    wire chain_en = mode_q[MW_CHAIN];
    wire irq_every = mode_q[MW_IRQ_SEL];
    wire is_block = (xfer_mode == XFER_BLOCK);
    wire [31:0] step = unit_step(unit_size);
    wire [31:0] src_next = next_addr(src_q, src_mode, step);
    wire [31:0] dst_next = next_addr(dst_q, dst_mode, step);
    // Outside block mode each activation moves one unit
    wire [15:0] blen_eff = is_block ? blen_q : CNT_ONE;
    wire [15:0] cnt_a_dec = cnt_a_q - CNT_ONE;

    // Hold drops a read or write request at once, even one still awaiting its ack
    wire hold = nmi_req & ~mode_q[MW_NMI_MODE];

    wire st_vec = (state_q == ST_VEC);
    wire st_fetch = (state_q == ST_FETCH);
    wire st_read = (state_q == ST_READ);
    wire st_write = (state_q == ST_WRITE);
    wire st_wback = (state_q == ST_WBACK);
    wire last_idx = (idx_q == DESC_LAST_IDX);

    wire req_read = st_read & push_s.ready & ~rd_fin_q & ~hold;
    wire req_write = st_write & pop_s.valid & ~hold;
    wire req_any = st_vec | st_fetch | st_wback | req_read | req_write;
    wire mem_go = mem_req & mem_ack;

    wire start = (state_q == ST_IDLE) & pend_q & act_en_q;
    wire blk_end = st_write & mem_go & (wr_left_q == CNT_ONE);
    wire cnt_done = (cnt_a_dec == CNT_ZERO);
    wire wb_done = st_wback & mem_go & last_idx;
    wire chain_go = wb_done & chain_en;
    wire irq_now = blk_end & (irq_every | cnt_done);

    wire [31:0] desc_addr = rf_q + desc_ofs(idx_q);
    logic [15:0] wb_word;

    always_comb begin
        wb_word = mode_q;
        case (idx_q)
            3'h0: wb_word = mode_q;
            3'h1: wb_word = cnt_a_q;
            3'h2: wb_word = blen_q;
            3'h3: wb_word = src_q[31:16];
            3'h4: wb_word = src_q[15:0];
            3'h5: wb_word = dst_q[31:16];
            3'h6: wb_word = dst_q[15:0];
            default: wb_word = mode_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM port and FIFO hookup

    assign mem_req = req_any & run;
    assign mem_we = st_write | st_wback;
    assign mem_addr = st_vec ? VECTOR_ADDR :
                      st_read ? src_q :
                      st_write ? dst_q :
                      desc_addr;
    assign mem_wdata = st_write ? pop_s.data : wb_word;

    assign push_s.valid = st_read & mem_go;
    assign push_s.data = mem_rdata;
    assign pop_s.ready = st_write & mem_go;

    assign act_enable = act_en_q;
    assign in_standby = stby_q;
    assign busy = (state_q != ST_IDLE);
    assign cpu_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_VEC;
                end
            end
            ST_VEC: begin
                if (mem_go) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_go && last_idx) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                // FIFO full or block read out: drain to the destination
                if (rd_fin_q || !push_s.ready) begin
                    state_d = ST_WRITE;
                end else if (mem_go && rd_left_q == CNT_ONE) begin
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (blk_end) begin
                    state_d = ST_WBACK;
                end else if (!pop_s.valid) begin
                    state_d = ST_READ;
                end
            end
            ST_WBACK: begin
                if (chain_go) begin
                    state_d = ST_FETCH;
                end else if (wb_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else if (run) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            idx_q <= '0;
        end else if (run) begin
            if (st_vec || wb_done || (st_fetch && mem_go && last_idx)
                || blk_end) begin
                idx_q <= '0;
            end else if ((st_fetch || st_wback) && mem_go) begin
                idx_q <= idx_q + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rf_q <= '0;
        end else if (run) begin
            if (st_vec && mem_go) begin
                rf_q <= {descriptor_base_upper, mem_rdata};
            end else if (chain_go) begin
                rf_q <= rf_q + DESC_STRIDE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working registers loaded from the descriptor

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= '0;
            blen_q <= '0;
        end else if (run && st_fetch && mem_go) begin
            if (idx_q == 3'h0) begin
                mode_q <= mem_rdata;
            end
            if (idx_q == 3'h2) begin
                blen_q <= mem_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_a_q <= '0;
        end else if (run) begin
            if (st_fetch && mem_go && idx_q == 3'h1) begin
                cnt_a_q <= mem_rdata;
            end else if (blk_end) begin
                cnt_a_q <= cnt_a_dec;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            src_q <= '0;
        end else if (run) begin
            if (st_fetch && mem_go && idx_q == 3'h3) begin
                src_q[31:16] <= mem_rdata;
            end else if (st_fetch && mem_go && idx_q == 3'h4) begin
                src_q[15:0] <= mem_rdata;
            end else if (blk_end && is_block && block_side) begin
                src_q <= blk_src_q;
            end else if (st_read && mem_go) begin
                src_q <= src_next;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dst_q <= '0;
        end else if (run) begin
            if (st_fetch && mem_go && idx_q == 3'h5) begin
                dst_q[31:16] <= mem_rdata;
            end else if (st_fetch && mem_go && idx_q == 3'h6) begin
                dst_q[15:0] <= mem_rdata;
            end else if (blk_end && is_block && !block_side) begin
                dst_q <= blk_dst_q;
            end else if (st_write && mem_go) begin
                dst_q <= dst_next;
            end
        end
    end

    // Start of the block area, restored once the block is done
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            blk_src_q <= '0;
            blk_dst_q <= '0;
        end else if (run && st_fetch && mem_go && last_idx) begin
            blk_src_q <= src_q;
            blk_dst_q <= {dst_q[31:16], mem_rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Block unit counters; a zero length wraps to the full 16-bit range

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_left_q <= '0;
            wr_left_q <= '0;
            rd_fin_q <= 1'b0;
        end else if (run) begin
            if (st_fetch && mem_go && last_idx) begin
                rd_left_q <= blen_eff;
                wr_left_q <= blen_eff;
                rd_fin_q <= 1'b0;
            end else begin
                if (st_read && mem_go) begin
                    rd_left_q <= rd_left_q - CNT_ONE;
                    rd_fin_q <= (rd_left_q == CNT_ONE);
                end
                if (st_write && mem_go) begin
                    wr_left_q <= wr_left_q - CNT_ONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Activation, enable, standby and CPU interrupt

    // Conversion end arriving as the pending flag is taken is kept
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pend_q <= 1'b0;
        end else if (run) begin
            if (conversion_end_irq) begin
                pend_q <= 1'b1;
            end else if (start) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Software re-arm wins over the count-end clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            act_en_q <= 1'b0;
        end else if (run) begin
            if (act_enable_set) begin
                act_en_q <= 1'b1;
            end else if (blk_end && cnt_done && !irq_every) begin
                act_en_q <= 1'b0;
            end
        end
    end

    // Mismatched bits leave standby unchanged
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stby_q <= 1'b0;
        end else if (clk_en && xfer_standby_hi == xfer_standby_lo) begin
            stby_q <= xfer_standby_hi;
        end
    end

    // Interrupt waits until the descriptor is back in RAM
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_due_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (run) begin
            irq_q <= wb_done & irq_due_q;
            if (irq_now) begin
                irq_due_q <= 1'b1;
            end else if (wb_done) begin
                irq_due_q <= 1'b0;
            end
        end else begin
            irq_q <= 1'b0;
        end
    end

endmodule : dbt_block_transfer

`default_nettype wire

// file: sim/dbt_ram_model.sv
// On-chip RAM model answering the engine's master port.
// Assumes one ref_clk; ack one or two cycles after a request.
`timescale 1ns/10ps
`default_nettype none
module dbt_ram_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [0:1023];
    logic [31:0] log_q [$];
    logic [15:0] rd_q = 16'h0000;
    logic ack_q = 1'b0;
    logic tick_q = 1'b0;
    // Bit 16 kept so a wrong upper descriptor half misses
    wire logic [9:0] idx = {mem_addr[16], mem_addr[9:1]};
    assign mem_ack = ack_q;
    // Idle bus shows inverted data so stale reads fail
    assign mem_rdata = ack_q ? rd_q : ~rd_q;
    ////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        tick_q <= ~tick_q;
        ack_q <= mem_req & ~ack_q & (~slow | tick_q);
        rd_q <= mem[idx];
        if (mem_req & ack_q) begin
            log_q.push_back(mem_addr);
            if (mem_we)
                mem[idx] = mem_wdata;
        end
    end
endmodule : dbt_ram_model
`default_nettype wire

// file: sim/dbt_block_transfer_monitor.sv
// Checker on the transfer engine's top-level ports.
// Assumes one ref_clk domain and synchronous active-high srst.
`timescale 1ns/10ps
`default_nettype none
module dbt_monitor (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic xfer_standby_hi,
    input wire logic xfer_standby_lo,
    input wire logic nmi_req,
    input wire logic busy,
    input wire logic in_standby,
    input wire logic cpu_irq,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    idle_quiet_a: assert property (
        !busy |-> !mem_req) else $error("request while idle");
    stby_quiet_a: assert property (
        in_standby |-> !mem_req) else $error("request in standby");
    stby_enter_a: assert property (
        clk_en && xfer_standby_hi && xfer_standby_lo |=> in_standby)
        else $error("standby not entered");
    stby_leave_a: assert property (
        clk_en && !xfer_standby_hi && !xfer_standby_lo |=> !in_standby)
        else $error("standby not left");
    stby_hold_a: assert property (
        clk_en && (xfer_standby_hi != xfer_standby_lo)
        |=> $stable(in_standby)) else $error("standby moved");
    req_hold_a: assert property (
        mem_req && !mem_ack && clk_en && !in_standby && !nmi_req
        |=> nmi_req || !clk_en || in_standby
        || (mem_req && $stable(mem_addr) && $stable(mem_we)))
        else $error("request dropped before ack");
    irq_pulse_a: assert property (
        cpu_irq |=> !cpu_irq) else $error("irq longer than one cycle");
    irq_after_wb_a: assert property (
        $rose(cpu_irq) |-> $past(mem_req && mem_ack && mem_we))
        else $error("irq not after write-back");
    cover property (cpu_irq);
    cover property (in_standby);
    cover property (nmi_req && busy && !mem_req);
endmodule : dbt_monitor
bind dbt_block_transfer dbt_monitor u_dbt_monitor (.ref_clk, .srst,
    .clk_en, .xfer_standby_hi, .xfer_standby_lo, .nmi_req, .busy,
    .in_standby, .cpu_irq, .mem_req, .mem_we, .mem_addr, .mem_ack);
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the descriptor block transfer engine.
// Assumes descriptors and data live in the RAM model.
`timescale 1ns/10ps
`default_nettype none
module tb_top import dbt_pkg::*;;
    localparam logic [31:0] VEC = 32'h0000_0020;
    localparam logic [31:0] RF = 32'h0001_0040;
    localparam logic [31:0] SRC = 32'h0000_0100;
    localparam logic [31:0] DST = 32'h0000_0200;
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] blen;
        logic [31:0] dst_end;
    } dbt_row_type;
    dbt_row_type rows [0:2] = '{'{16'h0003, 16'h0008, 32'h0000_0230},
        '{16'h0001, 16'h0009, 32'h0000_0212},
        '{16'h0002, 16'h0001, 32'h0000_0204}};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic xfer_standby_hi = 1'b0;
    logic xfer_standby_lo = 1'b0;
    logic conversion_end_irq = 1'b0;
    logic nmi_req = 1'b0;
    logic act_enable_set = 1'b0;
    logic slow = 1'b0;
    logic [15:0] descriptor_base_upper = 16'h0001;
    logic act_enable, in_standby, busy, cpu_irq, mem_req, mem_we, mem_ack;
    logic [31:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    int n_fail = 0;
    int samples_checked = 0;
    int irq_seen = 0;
    int irq0, r, b, k;
    dbt_block_transfer #(.VECTOR_ADDR(VEC)) u_dbt_block_transfer (
        .ref_clk, .srst, .clk_en, .xfer_standby_hi, .xfer_standby_lo,
        .conversion_end_irq, .nmi_req, .descriptor_base_upper,
        .act_enable_set, .act_enable, .in_standby, .busy, .cpu_irq,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    dbt_ram_model u_dbt_ram_model (.ref_clk, .slow, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (cpu_irq === 1'b1) irq_seen++;
    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic put(logic [31:0] a, logic [15:0] v);
        u_dbt_ram_model.mem[{a[16], a[9:1]}] = v;
    endtask : put
    function automatic logic [15:0] got(logic [31:0] a);
        return u_dbt_ram_model.mem[{a[16], a[9:1]}];
    endfunction : got
    task automatic wait_busy(logic v);
        for (int i = 0; i < 4000 && busy !== v; i++)
            @(negedge ref_clk);
        if (busy !== v) begin
            chk("busy", 32'(v), 32'(busy));
            test_done();
        end
    endtask : wait_busy
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask : pulse
    task automatic sb(logic h, logic l, logic exp);
        @(negedge ref_clk);
        xfer_standby_hi = h;
        xfer_standby_lo = l;
        @(negedge ref_clk);
        chk("standby", 32'(exp), 32'(in_standby));
    endtask : sb
    // Mode word: increment both sides, block, word, source area
    task automatic load(logic [15:0] cnt, logic [15:0] blen);
        put(VEC, RF[15:0]);
        put(RF + DOFS_MODE, 16'hA980);
        put(RF + DOFS_CNT_A, cnt);
        put(RF + DOFS_CNT_B, blen);
        put(RF + DOFS_SRC_HI, SRC[31:16]);
        put(RF + DOFS_SRC_LO, SRC[15:0]);
        put(RF + DOFS_DST_HI, DST[31:16]);
        put(RF + DOFS_DST_LO, DST[15:0]);
        for (k = 0; k < 32; k++) begin
            put(SRC + 32'(2 * k), 16'hC300 + 16'(k));
            put(DST + 32'(2 * k), 16'hDEAD);
        end
        pulse(act_enable_set);
        irq0 = irq_seen;
    endtask : load
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        chk("reset", 0, {busy, mem_req, cpu_irq, act_enable, in_standby});
        for (r = 0; r < 3; r++) begin
            load(rows[r].cnt, rows[r].blen);
            for (b = 1; b <= 32'(rows[r].cnt); b++) begin
                pulse(conversion_end_irq);
                wait_busy(1'b1);
                wait_busy(1'b0);
                repeat (3) @(negedge ref_clk);
                chk("irq", 32'(b == rows[r].cnt), irq_seen - irq0);
            end
            chk("enable", 0, 32'(act_enable));
            chk("cnt_a", 0, got(RF + DOFS_CNT_A));
            chk("blen", rows[r].blen, got(RF + DOFS_CNT_B));
            chk("src", SRC, {got(RF + 8), got(RF + 10)});
            chk("dst", rows[r].dst_end, {got(RF + 12), got(RF + 14)});
            for (k = 0; k < rows[r].cnt * rows[r].blen; k++)
                chk("data", 16'hC300 + 16'(k % rows[r].blen),
                    got(DST + 32'(2 * k)));
            chk("tail", 16'hDEAD, got(rows[r].dst_end));
        end
        pulse(conversion_end_irq);
        repeat (5) @(negedge ref_clk);
        chk("no_enable", 0, {busy, mem_req});
        clk_en = 1'b0;
        sb(1'b1, 1'b1, 1'b0);
        sb(1'b0, 1'b0, 1'b0);
        clk_en = 1'b1;
        sb(1'b1, 1'b0, 1'b0);
        sb(1'b1, 1'b1, 1'b1);
        sb(1'b0, 1'b1, 1'b1);
        sb(1'b0, 1'b0, 1'b0);
        load(16'h0001, 16'h0002);
        slow = 1'b1;
        nmi_req = 1'b1;
        u_dbt_ram_model.log_q.delete();
        pulse(conversion_end_irq);
        repeat (80) @(negedge ref_clk);
        chk("nmi_log", 8, u_dbt_ram_model.log_q.size());
        chk("nmi_busy", 1, 32'(busy));
        chk("vector", VEC, u_dbt_ram_model.log_q[0]);
        foreach (rows[k])
            chk("fetch", RF + 32'(k * 2 + (k > 1 ? 2 : 0)),
                u_dbt_ram_model.log_q[k + 1]);
        chk("fetch", RF + DOFS_SRC_HI, u_dbt_ram_model.log_q[4]);
        chk("fetch", RF + DOFS_DST_HI, u_dbt_ram_model.log_q[6]);
        nmi_req = 1'b0;
        wait_busy(1'b0);
        chk("resume", 32'hC300_C301, {got(DST), got(DST + 2)});
        test_done();
    end
endmodule : tb_top
`default_nettype wire
